// >>> palette_dac_consts.svh
// Constants for the palette lookup converter port logic
`ifndef PALETTE_DAC_CONSTS_SVH
`define PALETTE_DAC_CONSTS_SVH

`define SEL_ADDR_WR   2'h0
`define SEL_PALETTE   2'h1
`define SEL_MASK      2'h2
`define SEL_ADDR_RD   2'h3
`define PHASE_RED     2'h0
`define PHASE_GREEN   2'h1
`define PHASE_BLUE    2'h2
`define MASK_RESET    8'hff
`define ENTRIES       256
`define BLANK_LEVEL   6'h00

`endif

// >>> palette_dac_pkg.sv
// Types shared by the palette lookup converter port logic
package palette_dac_pkg;
	typedef logic [7:0] pixel_index_t;
	typedef logic [5:0] level_t;
	typedef logic [1:0] target_select_t;

	typedef struct packed {
		level_t red;
		level_t green;
		level_t blue;
	} color_s;

	typedef struct packed {
		logic [7:0] data;
		logic       oe;
	} host_drive_s;
endpackage

// >>> palette_dac_port_logic.sv
// Pixel port, host port and palette memory of the palette lookup converter
module palette_dac_port_logic
(
	input  wire logic                           CLK_SYS,
	input  wire logic                           RST_B,
	input  wire palette_dac_pkg::pixel_index_t  PIXEL_INDEX,
	input  wire logic                           BLANK_B,
	input  wire logic                           WR_B,
	input  wire logic                           RD_B,
	input  wire palette_dac_pkg::target_select_t TARGET_SELECT,
	input  wire logic [7:0]                     HOST_DATA_BUS_IN,
	output logic [7:0]                          HOST_DATA_BUS_OUT,
	output logic                                HOST_DATA_BUS_OE,
	output palette_dac_pkg::color_s             COLOR_OUT
);
	import palette_dac_pkg::*;
	`include "palette_dac_consts.svh"

	// ==========================================
	// Host strobe edge detection
	logic         wr_b_q;
	logic         rd_b_q;
	logic         wr_rise;
	logic         rd_rise;
	logic [7:0]   wr_data_q;
	target_select_t wr_sel_q;
	target_select_t rd_sel_q;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			wr_b_q <= 1'b1;
			rd_b_q <= 1'b1;
		end else begin
			wr_b_q <= WR_B;
			rd_b_q <= RD_B;
		end
	end

	// Data and select loaded on every edge while strobe is low, so the value of the last low cycle is kept
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			wr_data_q <= 8'h00;
			wr_sel_q  <= `SEL_ADDR_WR;
			rd_sel_q  <= `SEL_ADDR_WR;
		end else begin
			if (!WR_B) begin
				wr_data_q <= HOST_DATA_BUS_IN;
				wr_sel_q  <= TARGET_SELECT;
			end
			if (!RD_B) begin
				rd_sel_q <= TARGET_SELECT;
			end
		end
	end

	// ==========================================
	// Illegal access guard
	// Both strobes low together is not a valid access. It is remembered until both
	// strobes have been seen high again, and any strobe rise meanwhile is dropped.
	logic         clash_q;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			clash_q <= 1'b0;
		end else if (!WR_B && !RD_B) begin
			clash_q <= 1'b1;
		end else if (wr_b_q && rd_b_q) begin
			clash_q <= 1'b0;
		end
	end

	assign wr_rise = !wr_b_q && WR_B && !clash_q;
	assign rd_rise = !rd_b_q && RD_B && !clash_q;

	// ==========================================
	// Address register, phase counter, mask
	logic [7:0]   addr_q;
	logic [1:0]   phase_q;
	logic [7:0]   mask_q;
	level_t       red_q;
	level_t       green_q;
	color_s       palette [`ENTRIES];
	color_s       host_entry;
	logic         pal_wr;
	logic         pal_rd;
	logic         blue_step;
	logic         addr_wr;
	logic         mask_wr;

	// Every decode is a one-cycle pulse in the cycle after the strobe returns
	// high, built from the select and data held on the last low cycle.
	// Select 11 loads the address too; read and write mode share one register.
	assign addr_wr   = wr_rise
		&& (wr_sel_q == `SEL_ADDR_WR || wr_sel_q == `SEL_ADDR_RD);
	assign mask_wr   = wr_rise && (wr_sel_q == `SEL_MASK);
	assign pal_wr    = wr_rise && (wr_sel_q == `SEL_PALETTE);
	assign pal_rd    = rd_rise && (rd_sel_q == `SEL_PALETTE);
	assign blue_step = (pal_wr || pal_rd) && (phase_q == `PHASE_BLUE);

	// Host side view of the entry under the address register
	assign host_entry = palette[addr_q];

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			addr_q  <= 8'h00;
			phase_q <= `PHASE_RED;
		end else if (addr_wr) begin
			// A new address restarts the red, green, blue sequence
			addr_q  <= wr_data_q;
			phase_q <= `PHASE_RED;
		end else if (pal_wr || pal_rd) begin
			if (blue_step) begin
				// Entry complete: move to the next one, ff wraps to 00
				phase_q <= `PHASE_RED;
				addr_q  <= addr_q + 8'h01;
			end else begin
				phase_q <= phase_q + 2'h1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			mask_q <= `MASK_RESET;
		end else if (mask_wr) begin
			mask_q <= wr_data_q;
		end
	end

	// Red and green staged until the blue write completes the entry
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			red_q   <= 6'h00;
			green_q <= 6'h00;
		end else if (pal_wr) begin
			if (phase_q == `PHASE_RED) begin
				red_q <= wr_data_q[5:0];
			end
			if (phase_q == `PHASE_GREEN) begin
				green_q <= wr_data_q[5:0];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (pal_wr && phase_q == `PHASE_BLUE) begin
			palette[addr_q] <= '{red: red_q, green: green_q, blue: wr_data_q[5:0]};
		end
	end

	// ==========================================
	// Host read data
	logic [7:0] rd_data;

	// Follows the live select; registered, so valid one edge after the strobe falls
	always_comb begin
		case (TARGET_SELECT)
			`SEL_ADDR_RD,
			`SEL_ADDR_WR: rd_data = addr_q;
			`SEL_MASK:    rd_data = mask_q;
			`SEL_PALETTE: begin
				case (phase_q)
					`PHASE_RED:   rd_data = {2'h0, host_entry.red};
					`PHASE_GREEN: rd_data = {2'h0, host_entry.green};
					default:      rd_data = {2'h0, host_entry.blue};
				endcase
			end
			default: rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			HOST_DATA_BUS_OUT <= 8'h00;
		end else begin
			HOST_DATA_BUS_OUT <= rd_data;
		end
	end

	// Enable waits one edge so the registered read data is settled when driven
	assign HOST_DATA_BUS_OE = !RD_B && !rd_b_q;

	// ==========================================
	// Pixel pipeline
	// Index and blanking share one capture edge so they stay paired; the
	// colour appears two edges after the pixel was presented.
	pixel_index_t pix_q;
	logic         blank_b_q;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			pix_q     <= 8'h00;
			blank_b_q <= 1'b0;
		end else begin
			pix_q     <= PIXEL_INDEX & mask_q;
			blank_b_q <= BLANK_B;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			COLOR_OUT <= '0;
		end else if (!blank_b_q) begin
			// Blanking wins over any palette value; the index is not looked at
			COLOR_OUT <= '{`BLANK_LEVEL, `BLANK_LEVEL, `BLANK_LEVEL};
		end else begin
			COLOR_OUT <= palette[pix_q];
		end
	end
endmodule

// >>> palette_dac_assertions.sv
// Port checker for the palette converter logic
`include "palette_dac_consts.svh"
module pdac_chk
	import palette_dac_pkg::*;
(
	input wire logic				CLK_SYS,
	input wire logic				RST_B,
	input wire logic				BLANK_B,
	input wire logic				WR_B,
	input wire logic				RD_B,
	input wire palette_dac_pkg::target_select_t	TARGET_SELECT,
	input wire logic [7:0]				HOST_DATA_BUS_OUT,
	input wire logic				HOST_DATA_BUS_OE,
	input wire palette_dac_pkg::color_s		COLOR_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	blank_out_a: assert property (!BLANK_B |-> ##2 COLOR_OUT == {3{`BLANK_LEVEL}})
		else $error("blanked pixel not at blank level");
	blank_run_a: assert property (!BLANK_B[*2] |-> ##1 COLOR_OUT == {3{`BLANK_LEVEL}}
		##1 COLOR_OUT == {3{`BLANK_LEVEL}})
		else $error("blank run shows colour");
	oe_read_a: assert property (HOST_DATA_BUS_OE |-> !RD_B && !$past(RD_B))
		else $error("bus driven without read");
	oe_rise_a: assert property ($fell(RD_B) ##1 !RD_B |-> HOST_DATA_BUS_OE)
		else $error("read not driven");
	oe_end_a: assert property ($rose(RD_B) |-> !HOST_DATA_BUS_OE ##1 !HOST_DATA_BUS_OE)
		else $error("bus still driven");
	wr_quiet_a: assert property (!WR_B |-> !HOST_DATA_BUS_OE)
		else $error("bus driven during write");
	upper_zero_a: assert property (HOST_DATA_BUS_OE && TARGET_SELECT == `SEL_PALETTE
		&& $stable(TARGET_SELECT) |-> HOST_DATA_BUS_OUT[7:6] == 2'h0)
		else $error("colour read upper bits set");
	out_hold_a: assert property (HOST_DATA_BUS_OE && $past(HOST_DATA_BUS_OE)
		|-> $stable(HOST_DATA_BUS_OUT))
		else $error("read data moved");
	cover property (!BLANK_B);
	cover property (HOST_DATA_BUS_OE ##1 RD_B);
	cover property ($rose(WR_B));
	cover property ($rose(RD_B) && TARGET_SELECT == `SEL_PALETTE);
endmodule
bind palette_dac_port_logic pdac_chk pdac_chk_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
	.BLANK_B(BLANK_B), .WR_B(WR_B), .RD_B(RD_B), .TARGET_SELECT(TARGET_SELECT),
	.HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT), .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
	.COLOR_OUT(COLOR_OUT));

// >>> pixel_feed.sv
// Frame buffer side model: random pixels, blanked while idle
module pixel_feed (
	input wire logic	clk,
	input wire logic	on,
	output logic [7:0]	idx = 8'h00,
	output logic		blank_b = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 32'h2dd89a00;
	always @(posedge clk) begin
		idx <= on ? 8'(8'hfe + ($random(seed) & 3)) : ~idx;
		blank_b <= on & 1'($random(seed));
	end
endmodule

// >>> palette_dac_port_logic_tb.sv
// Self-checking bench for the palette converter logic
`include "palette_dac_consts.svh"
module palette_dac_port_logic_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import palette_dac_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, wr_b = 1'h1, rd_b = 1'h1, on = 1'h0, chk = 1'h0, blk, oe;
	logic [7:0] din = 8'h00, dout, idx, q, mask = 8'hff;
	target_select_t sel = 2'h0;
	color_s col, e1, e2;
	logic [17:0] pal [256];
	int mismatches = 0, total_checks = 0, seed = 32'h2dd89a00, i, j;
	always #5 clk = ~clk;
	palette_dac_port_logic palette_dac_port_logic_i (.CLK_SYS(clk), .RST_B(rst_b),
		.PIXEL_INDEX(idx), .BLANK_B(blk), .WR_B(wr_b), .RD_B(rd_b), .TARGET_SELECT(sel),
		.HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
		.COLOR_OUT(col));
	pixel_feed pixel_feed_i (.clk(clk), .on(on), .idx(idx), .blank_b(blk));
	task automatic cmp(string n, logic [17:0] e, logic [17:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic color_s exp_colour(logic b, logic [7:0] p);
		return b ? color_s'(pal[p & mask]) : '0;
	endfunction
	task automatic acc(logic w, target_select_t s, logic [7:0] d);
		@(posedge clk);
		sel <= s;
		din <= d;
		if (w) wr_b <= 1'h0;
		else rd_b <= 1'h0;
		repeat (2) @(posedge clk);
		#1 q = dout;
		cmp("drive", !w, oe);
		@(posedge clk);
		wr_b <= 1;
		rd_b <= 1;
		repeat (3) @(posedge clk);
	endtask
	task automatic complete_run;
		if (mismatches == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		e1 <= exp_colour(blk, idx);
		e2 <= e1;
	end
	always @(negedge clk) if (chk) cmp("colour", e2, col);
	initial begin
		#50000;
		mismatches++;
		complete_run;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1;
		acc(1, `SEL_ADDR_WR, 8'hfe);
		for (i = 0; i < 12; i++) begin
			j = $random(seed);
			acc(1, `SEL_PALETTE, 8'(j));
			pal[8'(8'hfe + i / 3)][17 - 6 * (i % 3) -: 6] = j[5:0];
		end
		acc(1, `SEL_ADDR_RD, 8'hfe);
		for (i = 0; i < 12; i++) begin
			acc(0, `SEL_PALETTE, 0);
			cmp("entry", pal[8'(8'hfe + i / 3)][17 - 6 * (i % 3) -: 6], q);
		end
		acc(0, `SEL_ADDR_RD, 0);
		cmp("address", 8'h02, q);
		acc(0, `SEL_ADDR_WR, 0);
		cmp("address", 8'h02, q);
		acc(0, `SEL_MASK, 0);
		cmp("mask", `MASK_RESET, q);
		for (i = 0; i < 2; i++) begin
			mask = 8'hff - 8'(i);
			acc(1, `SEL_MASK, mask);
			acc(0, `SEL_MASK, 8'h00);
			cmp("mask", mask, q);
			on <= 1'h1;
			repeat (3) @(posedge clk);
			chk = 1;
			repeat (200) @(posedge clk);
			chk = 0;
			on <= 0;
		end
		complete_run;
	end
endmodule
